// ---- fpec_pkg.sv ----
// Package of constants and types for the flash program/erase control block
package fpec_pkg;

   // ************************************************************
   // Register offsets (byte addresses on APB)
   // ************************************************************
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_KEY     = 8'h04;
   localparam logic [7:0] OFS_BUFPTR  = 8'h08;
   localparam logic [7:0] OFS_BUFDATA = 8'h0C;
   localparam logic [7:0] OFS_ISTAT   = 8'h10;
   localparam logic [7:0] OFS_ICLR    = 8'h14;
   localparam logic [7:0] OFS_IEN     = 8'h18;

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int unsigned BIT_START   = 15;
   localparam int unsigned BIT_PERMIT  = 14;
   localparam int unsigned BIT_FAULT   = 13;
   localparam int unsigned BIT_ERASE   = 6;
   localparam int unsigned OP_LSB      = 0;
   localparam int unsigned OP_W        = 4;
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [7:0]  KEY_FIRST   = 8'h55;
   localparam logic [7:0]  KEY_SECOND  = 8'hAA;

   // Operation field codes
   localparam logic [3:0] OP_BULK    = 4'hF;
   localparam logic [3:0] OP_GENSEG  = 4'hD;
   localparam logic [3:0] OP_SECSEG  = 4'hC;
   localparam logic [3:0] OP_WORD    = 4'h3;
   localparam logic [3:0] OP_PAGE    = 4'h2;
   localparam logic [3:0] OP_ROW     = 4'h1;
   localparam logic [3:0] OP_CONFIG  = 4'h0;

   // ************************************************************
   // Interrupt status bits
   // ************************************************************
   localparam int unsigned IRQ_W      = 2;
   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_FAULT  = 1;
   localparam logic [1:0]  IRQ_RST    = 2'h0;

   // ************************************************************
   // Row buffer geometry
   // ************************************************************
   localparam int unsigned ROW_WORDS  = 64;
   localparam int unsigned ROW_AW     = 6;
   localparam int unsigned WORD_W     = 24;

   // ************************************************************
   // Timing: operation length in oscillator cycles, scaled to clk
   // ************************************************************
   localparam int unsigned OSC_CYCLES   = 11064;
   localparam int unsigned OSC_KHZ      = 7370;
   localparam int unsigned CLK_KHZ      = 10000;
   localparam int unsigned OP_CYCLES_DEF = OSC_CYCLES * CLK_KHZ / OSC_KHZ;
   localparam int unsigned TIMER_W      = 16;

   // ************************************************************
   // Unlock and run sequencer states
   // ************************************************************
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_KEY1  = 2'b01,
      ST_ARMED = 2'b10,
      ST_BUSY  = 2'b11
   } fpec_state_type;

endpackage : fpec_pkg

// ---- fpec_buf_if.sv ----
// Interface between the control logic and its row holding buffer
`timescale 1ns/100ps
interface fpec_buf_if;
   import fpec_pkg::*;

   logic                permit_ops_bit;
   logic [ROW_AW-1:0]   wrAddr;
   logic [WORD_W-1:0]   wrData;
   logic                rdEn;
   logic [ROW_AW-1:0]   rdAddr;
   logic [WORD_W-1:0]   rdData;

   modport ctrl
   (
      output permit_ops_bit,
      output wrAddr,
      output wrData,
      output rdEn,
      output rdAddr,
      input  rdData
   );

   modport mem
   (
      input  permit_ops_bit,
      input  wrAddr,
      input  wrData,
      input  rdEn,
      input  rdAddr,
      output rdData
   );

endinterface : fpec_buf_if

// ---- fpec_row_buffer.sv ----
// Holding buffer for one row of programming data, registered read
`timescale 1ns/100ps
module fpec_row_buffer
   import fpec_pkg::*;
(
   input wire logic clk,
   fpec_buf_if.mem  bus
);

   logic [WORD_W-1:0] mem [ROW_WORDS];
   logic [WORD_W-1:0] rdData_q;

   always_ff @(posedge clk)
   begin
      if (bus.permit_ops_bit)
      begin
         mem[bus.wrAddr] <= bus.wrData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (bus.rdEn)
      begin
         rdData_q <= mem[bus.rdAddr];
      end
   end

   assign bus.rdData = rdData_q;

endmodule : fpec_row_buffer

// ---- fpec_top.sv ----
// Flash program/erase control: key unlock, control register, timed run
// ************************************************************
// Overview of operation
// - Operation lasts a fixed count of oscillator cycles, scaled to clk.
// - Setting start launches the operation; hardware clears start at end.
// - Key register low byte write-only key; upper byte reads zero.
// - Start is set-only; reads zero, since a read during a run is held until the run ends.
// - Operations run only while permit bit is one.
// - Fault flag set on improper start or termination, not on success.
// - Erase bit selects erase or program meaning of operation field.
// - Erase codes: bulk, general segment, secure segment, page, config.
// - Program codes: word, row, config byte; others are no operation.
// - Unlisted operation codes are unimplemented and run nothing.
// - Permit, fault and low op bits clear only on power-on; start also clears on sysRst.
// - Unimplemented control bits ignore writes and read zero.
// - Processor is stalled from operation start until it finishes.
// - One row of holding buffers is loaded sequentially before row program.
// - Page erase clears eight aligned rows in one operation.
// ************************************************************
`timescale 1ns/100ps
module fpec_top
   import fpec_pkg::*;
#(
   parameter int unsigned OP_CYCLES = OP_CYCLES_DEF
)
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               sysRst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    irq,
   output logic                    cpuStall,
   output logic                    opActive,
   output logic                    opErase,
   output logic      [OP_W-1:0]    opCode,
   output logic                    opDone,
   output logic                    rowValid,
   output logic      [ROW_AW-1:0]  rowIndex,
   output logic      [WORD_W-1:0]  rowData
);

   // ************************************************************
   // Declarations
   // ************************************************************
   fpec_state_type     state_q;
   fpec_state_type     state_d;
   logic               permit_q;
   logic               fault_q;
   logic               erase_q;
   logic [1:0]         opLo_q;
   logic [1:0]         opHi_q;
   logic [OP_W-1:0]    opField;
   logic [TIMER_W-1:0] timer_q;
   logic [ROW_AW-1:0]  bufPtr_q;
   logic [ROW_AW-1:0]  rowPtr_q;
   logic               rowRun_q;
   logic               rowValid_q;
   logic [ROW_AW-1:0]  rowIndex_q;
   logic               opDone_q;
   logic [IRQ_W-1:0]   istat_q;
   logic [IRQ_W-1:0]   ien_q;
   logic [31:0]        prdata_q;
   logic               pslverr_q;
   logic               access;
   logic               wrAcc;
   logic               rdAcc;
   logic               mapped;
   logic               wrCtrl;
   logic               wrKey;
   logic               startReq;
   logic               startOk;
   logic               startBad;
   logic               finish;
   logic               abort;
   logic [IRQ_W-1:0]   events;

   fpec_buf_if buf_if ();

   localparam logic [TIMER_W-1:0] OP_LEN = TIMER_W'(OP_CYCLES);

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic op_valid(input logic erase,
                                     input logic [OP_W-1:0] op);
      logic ok;
      ok = 1'b0;
      if (erase)
      begin
         ok = (op == OP_BULK) || (op == OP_GENSEG) ||
              (op == OP_SECSEG) || (op == OP_PAGE) ||
              (op == OP_CONFIG);
      end
      else
      begin
         ok = (op == OP_WORD) || (op == OP_ROW) ||
              (op == OP_CONFIG);
      end
      return ok;
   endfunction : op_valid

   function automatic logic is_addr(input logic [7:0] a,
                                    input logic [7:0] ofs);
      return a == ofs;
   endfunction : is_addr

   // ************************************************************
   // APB decode
   // ************************************************************
   assign pready  = (state_q != ST_BUSY);
   assign access  = psel && penable && pready;
   assign wrAcc   = access && pwrite;
   assign rdAcc   = access && !pwrite;
   assign mapped  = is_addr(paddr, OFS_CONTROL) || is_addr(paddr, OFS_KEY) ||
                    is_addr(paddr, OFS_BUFPTR) || is_addr(paddr, OFS_BUFDATA) ||
                    is_addr(paddr, OFS_ISTAT) || is_addr(paddr, OFS_ICLR) ||
                    is_addr(paddr, OFS_IEN);
   assign wrCtrl  = wrAcc && is_addr(paddr, OFS_CONTROL);
   assign wrKey   = wrAcc && is_addr(paddr, OFS_KEY);
   assign startReq = wrCtrl && pwdata[BIT_START];

   // Start needs unlock, permit and an implemented code
   assign startOk  = startReq && (state_q == ST_ARMED) &&
                     pwdata[BIT_PERMIT] &&
                     op_valid(pwdata[BIT_ERASE],
                              pwdata[OP_LSB +: OP_W]);
   assign startBad = startReq && !startOk;
   assign finish   = (state_q == ST_BUSY) && (timer_q == TIMER_W'(1));
   assign abort    = sysRst && (state_q == ST_BUSY);

   // ************************************************************
   // Unlock and run sequencer
   // ************************************************************
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE, ST_KEY1, ST_ARMED:
         begin
            if (startOk)
            begin
               state_d = ST_BUSY;
            end
            else if (wrKey && pwdata[7:0] == KEY_FIRST)
            begin
               state_d = ST_KEY1;
            end
            else if (wrKey && pwdata[7:0] == KEY_SECOND &&
                     state_q == ST_KEY1)
            begin
               state_d = ST_ARMED;
            end
            else if (wrAcc)
            begin
               state_d = ST_IDLE;
            end
         end
         ST_BUSY:
         begin
            if (finish)
            begin
               state_d = ST_IDLE;
            end
         end
      endcase
      if (sysRst)
      begin
         state_d = ST_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Operation timer, loaded at start
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         timer_q <= '0;
      end
      else if (startOk)
      begin
         timer_q <= OP_LEN;
      end
      else if (state_q == ST_BUSY)
      begin
         timer_q <= timer_q - TIMER_W'(1);
      end
   end

   // ************************************************************
   // Control register bits
   // ************************************************************
   // Power-on-only bits: permit, fault, low op bits
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         permit_q <= CONTROL_RST[BIT_PERMIT];
         fault_q  <= CONTROL_RST[BIT_FAULT];
         opLo_q   <= CONTROL_RST[1:0];
      end
      else
      begin
         if (wrCtrl)
         begin
            permit_q  <= pwdata[BIT_PERMIT];
            opLo_q    <= pwdata[1:0];
         end
         if (startBad || abort)
         begin
            fault_q <= 1'b1;
         end
         else if (wrCtrl)
         begin
            fault_q <= pwdata[BIT_FAULT];
         end
      end
   end

   // Bits cleared by any reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         erase_q <= CONTROL_RST[BIT_ERASE];
         opHi_q  <= CONTROL_RST[3:2];
      end
      else if (sysRst)
      begin
         erase_q <= CONTROL_RST[BIT_ERASE];
         opHi_q  <= CONTROL_RST[3:2];
      end
      else if (wrCtrl)
      begin
         erase_q <= pwdata[BIT_ERASE];
         opHi_q  <= pwdata[3:2];
      end
   end

   // ************************************************************
   // Row holding buffer load and readout
   // ************************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bufPtr_q <= '0;
      end
      else if (wrAcc && is_addr(paddr, OFS_BUFPTR))
      begin
         bufPtr_q <= pwdata[ROW_AW-1:0];
      end
      else if (wrAcc && is_addr(paddr, OFS_BUFDATA))
      begin
         bufPtr_q <= bufPtr_q + ROW_AW'(1);
      end
   end

   // Stream the row out once at the start of a row program
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rowRun_q <= 1'b0;
         rowPtr_q <= '0;
      end
      else if (startOk && !pwdata[BIT_ERASE] &&
               pwdata[OP_LSB +: OP_W] == OP_ROW)
      begin
         rowRun_q <= 1'b1;
         rowPtr_q <= '0;
      end
      else if (rowRun_q)
      begin
         rowPtr_q <= rowPtr_q + ROW_AW'(1);
         if (rowPtr_q == ROW_AW'(ROW_WORDS - 1) || abort)
         begin
            rowRun_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rowValid_q <= 1'b0;
         rowIndex_q <= '0;
      end
      else
      begin
         rowValid_q <= rowRun_q;
         rowIndex_q <= rowPtr_q;
      end
   end

   assign buf_if.permit_ops_bit   = wrAcc && is_addr(paddr, OFS_BUFDATA);
   assign buf_if.wrAddr = bufPtr_q;
   assign buf_if.wrData = pwdata[WORD_W-1:0];
   assign buf_if.rdEn   = rowRun_q;
   assign buf_if.rdAddr = rowPtr_q;

   fpec_row_buffer u_row_buffer
   (
      .clk (clk),
      .bus (buf_if.mem)
   );

   // ************************************************************
   // Interrupt status, clear and enable
   // ************************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         opDone_q <= 1'b0;
      end
      else
      begin
         opDone_q <= finish;
      end
   end

   assign events[IRQ_DONE]  = finish;
   assign events[IRQ_FAULT] = startBad || abort;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         istat_q <= IRQ_RST;
      end
      else
      begin
         if (wrAcc && is_addr(paddr, OFS_ICLR))
         begin
            istat_q <= (istat_q & ~pwdata[IRQ_W-1:0]) | events;
         end
         else
         begin
            istat_q <= istat_q | events;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ien_q <= IRQ_RST;
      end
      else if (wrAcc && is_addr(paddr, OFS_IEN))
      begin
         ien_q <= pwdata[IRQ_W-1:0];
      end
   end

   // ************************************************************
   // Read data and error answer
   // ************************************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      // Refresh while stalled, so a held read sees the finished state
      else if (psel && (!penable || !pready))
      begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= !mapped;
         if (!pwrite)
         begin
            unique case (paddr)
               OFS_CONTROL:
               begin
                  prdata_q[BIT_START]  <= (state_d == ST_BUSY);
                  prdata_q[BIT_PERMIT] <= permit_q;
                  prdata_q[BIT_FAULT]  <= fault_q;
                  prdata_q[BIT_ERASE]  <= erase_q;
                  prdata_q[OP_LSB +: OP_W] <= opField;
               end
               OFS_ISTAT:
               begin
                  prdata_q[IRQ_W-1:0] <= istat_q;
               end
               OFS_IEN:
               begin
                  prdata_q[IRQ_W-1:0] <= ien_q;
               end
               OFS_BUFPTR:
               begin
                  prdata_q[ROW_AW-1:0] <= bufPtr_q;
               end
               default:
               begin
                  prdata_q <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign prdata   = rdAcc ? prdata_q : 32'h0000_0000;
   assign pslverr  = access && pslverr_q;
   assign irq      = |(istat_q & ien_q);
   assign cpuStall = (state_q == ST_BUSY);
   assign opActive = (state_q == ST_BUSY);
   assign opErase  = erase_q;
   assign opField  = {opHi_q, opLo_q};
   assign opCode   = opField;
   assign opDone   = opDone_q;
   assign rowValid = rowValid_q;
   assign rowIndex = rowIndex_q;
   assign rowData  = buf_if.rdData;

endmodule : fpec_top

// ---- fpec_top_props.sv ----
// Assertion checker for the flash program/erase control block
`timescale 1ns/100ps
module fpec_top_props
   import fpec_pkg::*;
#(
   parameter int unsigned OP_CYCLES = OP_CYCLES_DEF
)
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              sysRst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              irq,
   input wire logic              cpuStall,
   input wire logic              opActive,
   input wire logic              opErase,
   input wire logic [OP_W-1:0]   opCode,
   input wire logic              opDone,
   input wire logic              rowValid,
   input wire logic [ROW_AW-1:0] rowIndex,
   input wire logic [WORD_W-1:0] rowData
);
   // ********
   // Run length counter and bus decode
   // ********
   logic [15:0] runCnt_q;
   logic        ctlWr;
   logic        ctlRd;
   assign ctlWr = psel && penable && pready && pwrite && paddr == OFS_CONTROL;
   assign ctlRd = psel && penable && !pwrite && paddr == OFS_CONTROL;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         runCnt_q <= 16'h0000;
      else if (cpuStall)
         runCnt_q <= runCnt_q + 16'h0001;
      else
         runCnt_q <= 16'h0000;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_stall_bus;
      cpuStall == opActive && pready == !cpuStall;
   endproperty
   a_stall_bus: assert property (p_stall_bus)
      else $error("stall and ready disagree");
   property p_run_len;
      $fell(cpuStall) && !$past(sysRst) |->
         runCnt_q inside {[OP_CYCLES-1:OP_CYCLES]};
   endproperty
   a_run_len: assert property (p_run_len)
      else $error("run length wrong");
   property p_done;
      $fell(cpuStall) && !$past(sysRst) |-> ##[0:1] opDone;
   endproperty
   a_done: assert property (p_done)
      else $error("no done pulse");
   property p_done_one;
      opDone |=> !opDone;
   endproperty
   a_done_one: assert property (p_done_one)
      else $error("done pulse too long");
   property p_row_seq;
      rowValid && rowIndex != 6'h3F |=>
         rowValid && rowIndex == $past(rowIndex) + 6'h01;
   endproperty
   a_row_seq: assert property (p_row_seq)
      else $error("row stream broken");
   property p_row_only;
      rowValid |-> cpuStall && !opErase && opCode == OP_ROW;
   endproperty
   a_row_only: assert property (p_row_only)
      else $error("row stream outside row program");
   property p_permit;
      ctlWr && pwdata[BIT_START] && !pwdata[BIT_PERMIT] |=> !cpuStall;
   endproperty
   a_permit: assert property (p_permit)
      else $error("run without permit");
   property p_fields;
      ctlWr && !sysRst |=> opErase == $past(pwdata[BIT_ERASE])
         && opCode == $past(pwdata[3:0]);
   endproperty
   a_fields: assert property (p_fields)
      else $error("operation fields not stored");
   property p_ctl_read;
      ctlRd |-> prdata[31:16] == 16'h0000 && prdata[12:7] == 6'h00
         && prdata[5:4] == 2'b00;
   endproperty
   a_ctl_read: assert property (p_ctl_read)
      else $error("unimplemented bits read nonzero");
   property p_key_read;
      psel && penable && !pwrite && paddr == OFS_KEY |-> prdata == 32'h0;
   endproperty
   a_key_read: assert property (p_key_read)
      else $error("key reads nonzero");
   c_row: cover property ($rose(rowValid));
   c_done: cover property (opDone);
   c_err: cover property (psel && penable && pslverr);
   c_irq: cover property (irq);
endmodule : fpec_top_props

bind fpec_top fpec_top_props #(.OP_CYCLES(OP_CYCLES)) u_props
(
   .clk, .rst, .sysRst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .irq, .cpuStall, .opActive, .opErase,
   .opCode, .opDone, .rowValid, .rowIndex, .rowData
);

// ---- test_fpec_top.sv ----
// Self-checking bench for the flash program/erase control block
`timescale 1ns/100ps
module test_fpec_top;
   import fpec_pkg::*;
   localparam int unsigned NCYC = 100;
   logic              clk, rst, sysRst, psel, penable, pwrite;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rdVal;
   logic              pready, pslverr, irq, cpuStall, opActive;
   logic              opErase, opDone, rowValid, rdErr;
   logic [OP_W-1:0]   opCode;
   logic [ROW_AW-1:0] rowIndex;
   logic [WORD_W-1:0] rowData;
   logic [WORD_W-1:0] rowMem [ROW_WORDS];
   int                failCount, totalChecks, rowCount;

   fpec_top #(.OP_CYCLES(NCYC)) DUT
   (
      .clk, .rst, .sysRst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq, .cpuStall, .opActive, .opErase,
      .opCode, .opDone, .rowValid, .rowIndex, .rowData
   );

   always #50 clk = ~clk;

   // ********
   // Checking and bus tasks
   // ********
   task chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         failCount++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task results;
      if (failCount == 0 && totalChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 1000);
      rdVal = prdata;
      rdErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 1000)
         chk(32'h0000_0000, 32'h0000_0001);
   endtask : apb

   function automatic logic okCode(input logic [4:0] eo);
      okCode = eo inside {5'h1F, 5'h1D, 5'h1C, 5'h12, 5'h10,
                          5'h03, 5'h01, 5'h00};
   endfunction : okCode

   function automatic logic [31:0] ctlExp(input logic [15:0] c,
                                          input logic ok);
      ctlExp = {16'h0000, c & 16'h404F};
      ctlExp[BIT_FAULT] = !ok;
   endfunction : ctlExp

   // Unlock, start, then check the outcome
   task launch(input logic [4:0] eo, input logic brk, input logic pmt);
      logic [15:0] c;
      logic        ok;
      c  = {1'b0, pmt, 7'h00, eo[4], 2'b00, eo[3:0]};
      ok = okCode(eo) && pmt && !brk;
      rowCount = 0;
      apb(1'b1, OFS_CONTROL, {16'h0000, c});
      apb(1'b1, OFS_KEY, 32'h0000_0055);
      if (brk)
         apb(1'b1, OFS_IEN, 32'h0000_0003);
      apb(1'b1, OFS_KEY, 32'h0000_00AA);
      apb(1'b1, OFS_CONTROL, {16'h0000, c | 16'h8000});
      @(negedge clk);
      chk({31'h0, cpuStall}, {31'h0, ok});
      chk({27'h0, opErase, opCode}, {27'h0, eo});
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      chk(rdVal, ctlExp(c, ok));
      apb(1'b0, OFS_ISTAT, 32'h0000_0000);
      chk(rdVal, ok ? 32'h0000_0001 : 32'h0000_0002);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0000_0001);
      chk(32'(rowCount), (eo == 5'h01 && ok) ? 32'd64 : 32'd0);
      apb(1'b1, OFS_ICLR, 32'h0000_0003);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
   endtask : launch

   always @(posedge clk)
   begin
      if (rowValid === 1'b1)
      begin
         chk({8'h00, rowData}, {8'h00, rowMem[rowIndex]});
         rowCount++;
      end
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      failCount++;
      results();
   end

   // ********
   // Main sequence
   // ********
   initial
   begin
      logic [15:0] w;
      clk = 1'b0;
      rst = 1'b1;
      sysRst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      failCount = 0;
      totalChecks = 0;
      void'($urandom(32'h8f34));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      chk(rdVal, 32'h0000_0000);
      apb(1'b1, OFS_KEY, 32'h0000_FF55);
      apb(1'b0, OFS_KEY, 32'h0000_0000);
      chk(rdVal, 32'h0000_0000);
      apb(1'b0, OFS_ISTAT, 32'h0000_0000);
      chk(rdVal, 32'h0000_0000);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk({31'h0, rdErr}, 32'h0000_0001);
      for (int i = 0; i < 6; i++)
      begin
         w = (i == 0) ? 16'h7FFF : 16'($urandom & 32'h0000_7FFF);
         apb(1'b1, OFS_CONTROL, {16'h0000, w});
         apb(1'b0, OFS_CONTROL, 32'h0000_0000);
         chk(rdVal, {16'h0000, w & 16'h604F});
      end
      apb(1'b1, OFS_IEN, 32'h0000_0003);
      apb(1'b1, OFS_BUFPTR, 32'h0000_0000);
      for (int i = 0; i < ROW_WORDS; i++)
      begin
         rowMem[i] = WORD_W'($urandom);
         apb(1'b1, OFS_BUFDATA, {8'h00, rowMem[i]});
      end
      for (int i = 0; i < 32; i++)
         launch(5'(i), 1'b0, 1'b1);
      // Page erase cut short by the other reset
      apb(1'b1, OFS_KEY, 32'h0000_0055);
      apb(1'b1, OFS_KEY, 32'h0000_00AA);
      apb(1'b1, OFS_CONTROL, 32'h0000_C042);
      repeat (10) @(posedge clk);
      sysRst <= 1'b1;
      @(posedge clk);
      sysRst <= 1'b0;
      @(negedge clk);
      chk({31'h0, cpuStall}, 32'h0000_0000);
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      chk(rdVal, 32'h0000_6002);
      apb(1'b0, OFS_ISTAT, 32'h0000_0000);
      chk(rdVal, 32'h0000_0002);
      apb(1'b1, OFS_ICLR, 32'h0000_0003);
      launch(5'h12, 1'b1, 1'b1);
      launch(5'h01, 1'b0, 1'b0);
      apb(1'b1, OFS_CONTROL, 32'h0000_604F);
      sysRst <= 1'b1;
      @(posedge clk);
      sysRst <= 1'b0;
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      chk(rdVal, 32'h0000_6003);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
      chk(rdVal, 32'h0000_0000);
      results();
   end
endmodule : test_fpec_top
